//--- hdl/aofe_core.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

//Operation
//- input above top reference: over flag high, word forced to all ones
//- input below bottom reference: under flag high, word forced to all zeros
//- both range flags low while input stays inside the reference range
//- data enable high with global enable high: data tri-stated, flags driven
//- global enable low: data and both flags tri-stated
//- enables act asynchronously and touch only the output drivers
//- output register keeps updating while outputs are tri-stated
//- open data enable reads low, open global enable reads high
//- polarity high: sample on falling edge, data changes after rising edge
//- polarity low: sample on rising edge, data changes after falling edge
//- open polarity select defaults high
//- sync output high while tracking, low while holding and comparing
//- value at falling edge of sync output is the one digitized
//- both inversions low: straight binary, zeros bottom, ones top
//- msb inversion flips bit 9
//- low-bit inversion flips bits 0 to 8
//- range flags untouched by the inversion controls
//- open inversion inputs default low, giving straight binary
module aofe_core
    import aofe_pkg::*;
(
    input wire logic sys_clk_i, // system clock, 10 MHz
    input wire logic nrst_i, // async reset, active low
    input wire logic clk_en_i, // freezes all state while low
    input wire logic conv_clk_i, // converter clock pin from host
    input wire logic [AOFE_IN_W-1:0] analog_input_i, // digitised analog level
    input wire logic data_out_enable_n_i, // data drivers enable, low active
    input wire logic global_out_enable_i, // all drivers enable, high active
    input wire logic clk_phase_sel_i, // converter clock polarity select
    input wire logic msb_invert_i, // invert bit 9
    input wire logic low_bits_invert_i, // invert bits 0 to 8
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [AOFE_ADDR_W-1:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [AOFE_WORD_W-1:0] sample_word_o, // data pins
    output logic sample_word_oe_o, // data pins driven
    output logic over_range_flag_o, // over range pin
    output logic over_range_flag_oe_o, // over range pin driven
    output logic under_range_flag_o, // under range pin
    output logic under_range_flag_oe_o, // under range pin driven
    output logic sample_window_o, // high while tracking
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o // apb error
);

    // quantise against the bottom reference; top sits a full span above it
    function automatic aofe_sample_type aofe_convert(
        input logic [AOFE_IN_W-1:0] level,
        input logic [AOFE_IN_W-1:0] bottom
    );
        aofe_sample_type s;
        logic [AOFE_IN_W:0] diff;
        diff = {1'b0, level} - {1'b0, bottom};
        s.over = 1'b0;
        s.under = 1'b0;
        s.word = diff[AOFE_WORD_W-1:0];
        if (level < bottom)
        begin
            s.under = 1'b1;
            s.word = AOFE_ZERO_SCALE;
        end
        else if (diff > AOFE_SPAN)
        begin
            s.over = 1'b1;
            s.word = AOFE_FULL_SCALE;
        end
        return s; // flags stay low in range
    endfunction : aofe_convert

    // format applies to the word only; flags pass untouched
    function automatic aofe_sample_type aofe_format(
        input aofe_sample_type s,
        input logic msb_invert,
        input logic low_bits_invert
    );
        aofe_sample_type f;
        f = s; // straight binary when both low
        if (msb_invert)
        begin
            f.word[AOFE_MSB] = ~s.word[AOFE_MSB];
        end
        if (low_bits_invert)
        begin
            f.word[AOFE_MSB-1:0] = s.word[AOFE_MSB-1:0] ^ AOFE_LOW_MASK;
        end
        return f;
    endfunction : aofe_format

    // one transition detector for both converter clock edges
    function automatic logic aofe_edge(
        input logic prev,
        input logic cur,
        input logic rising
    );
        logic hit;
        if (rising)
        begin
            hit = ~prev & cur;
        end
        else
        begin
            hit = prev & ~cur;
        end
        return hit;
    endfunction : aofe_edge

    // address map check shared by the read and the write path
    function automatic logic aofe_mapped(
        input logic [AOFE_ADDR_W-1:0] addr
    );
        logic hit;
        hit = 1'b0;
        if (addr == AOFE_CTRL_OFFSET)
        begin
            hit = 1'b1;
        end
        else if (addr == AOFE_REFBOT_OFFSET)
        begin
            hit = 1'b1;
        end
        else if (addr == AOFE_STATUS_OFFSET)
        begin
            hit = 1'b1;
        end
        return hit;
    endfunction : aofe_mapped

    // status word: output register, window and resolved polarity
    function automatic logic [31:0] aofe_status(
        input aofe_sample_type r,
        input logic win,
        input logic phase
    );
        logic [31:0] st;
        st = 32'h0000_0000;
        st[AOFE_WORD_W-1:0] = r.word;
        st[AOFE_ST_OVER_BIT] = r.over;
        st[AOFE_ST_UNDER_BIT] = r.under;
        st[AOFE_ST_WINDOW_BIT] = win;
        st[AOFE_ST_PHASE_BIT] = phase;
        return st;
    endfunction : aofe_status

    logic [AOFE_CTRL_W-1:0] ctrl;
    logic [AOFE_CTRL_W-1:0] next_ctrl;
    logic [AOFE_IN_W-1:0] ref_bottom;
    logic [AOFE_IN_W-1:0] next_ref_bottom;
    aofe_bus_state_type bus_state;
    aofe_bus_state_type next_bus_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    aofe_pins_type pins;
    logic conv_clk_q;
    logic next_conv_clk_q;
    logic sample_edge;
    logic out_edge;
    aofe_sample_type held;
    aofe_sample_type next_held;
    aofe_sample_type pipe [AOFE_PIPE_DEPTH];
    aofe_sample_type next_pipe [AOFE_PIPE_DEPTH];
    aofe_sample_type out_reg;
    aofe_sample_type next_out_reg;
    logic window;
    logic next_window;

    // an open pin takes its resistor level until software marks it connected
    always_comb
    begin
        pins.den_n = ctrl[AOFE_CONN_DEN_BIT] ? data_out_enable_n_i
                                             : AOFE_PULL_DEN_N;
        pins.gen = ctrl[AOFE_CONN_GEN_BIT] ? global_out_enable_i
                                           : AOFE_PULL_GEN;
        pins.phase = ctrl[AOFE_CONN_PHASE_BIT] ? clk_phase_sel_i
                                               : AOFE_PULL_PHASE;
        pins.msb_invert = ctrl[AOFE_CONN_MSB_INVERT_BIT] ? msb_invert_i
                                             : AOFE_PULL_MSB_INVERT;
        pins.low_bits_invert = ctrl[AOFE_CONN_LOW_BITS_INVERT_BIT] ? low_bits_invert_i
                                             : AOFE_PULL_LOW_BITS_INVERT;
    end

    // drivers follow the enables with no clock in the path, hence not from flops
    always_comb
    begin
        sample_word_oe_o = pins.gen & ~pins.den_n;
        over_range_flag_oe_o = pins.gen;
        under_range_flag_oe_o = pins.gen;
    end

    always_comb
    begin
        sample_edge = aofe_edge(conv_clk_q, conv_clk_i, ~pins.phase);
        out_edge = aofe_edge(conv_clk_q, conv_clk_i, pins.phase);
    end

    // converter pipeline; output enables never gate it, so data stays fresh
    always_comb
    begin
        next_conv_clk_q = conv_clk_i;
        next_held = held;
        next_pipe = pipe;
        next_out_reg = out_reg;
        next_window = window;
        if (sample_edge)
        begin
            next_held = aofe_convert(analog_input_i, ref_bottom);
            next_window = 1'b0; // hold and compare
        end
        else if (out_edge)
        begin
            next_window = 1'b1; // back to tracking
            next_pipe[0] = held;
            for (int i = 1; i < AOFE_PIPE_DEPTH; i++)
            begin
                next_pipe[i] = pipe[i-1];
            end
            // inversion levels are taken only here, at the latch load
            next_out_reg = aofe_format(pipe[AOFE_PIPE_DEPTH-1],
                                       pins.msb_invert, pins.low_bits_invert);
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            conv_clk_q <= 1'b0;
            held <= '0;
            for (int i = 0; i < AOFE_PIPE_DEPTH; i++)
            begin
                pipe[i] <= '0;
            end
            out_reg <= '0;
            window <= 1'b1;
        end
        else if (clk_en_i)
        begin
            conv_clk_q <= next_conv_clk_q;
            held <= next_held;
            pipe <= next_pipe;
            out_reg <= next_out_reg;
            window <= next_window;
        end
    end

    always_comb
    begin
        sample_word_o = out_reg.word;
        over_range_flag_o = out_reg.over;
        under_range_flag_o = out_reg.under;
        sample_window_o = window;
    end

    // apb slave with one wait state so that ready and read data come from flops
    always_comb
    begin
        next_bus_state = bus_state;
        next_ctrl = ctrl;
        next_ref_bottom = ref_bottom;
        next_prdata = prdata_o;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        case (bus_state)
            AOFE_BUS_IDLE:
            begin
                if (psel_i && penable_i)
                begin
                    next_bus_state = AOFE_BUS_ANSWER;
                    next_pready = 1'b1;
                    next_prdata = 32'h0000_0000;
                    next_pslverr = ~aofe_mapped(paddr_i);
                    if (paddr_i == AOFE_CTRL_OFFSET)
                    begin
                        next_prdata[AOFE_CTRL_W-1:0] = ctrl;
                    end
                    else if (paddr_i == AOFE_REFBOT_OFFSET)
                    begin
                        next_prdata[AOFE_IN_W-1:0] = ref_bottom;
                    end
                    else if (paddr_i == AOFE_STATUS_OFFSET)
                    begin
                        next_prdata = aofe_status(out_reg, window, pins.phase);
                    end
                end
            end
            AOFE_BUS_ANSWER:
            begin
                next_bus_state = AOFE_BUS_IDLE;
                next_pready = 1'b0;
                next_pslverr = 1'b0;
                // the write lands on the edge that sees ready high
                if (psel_i && penable_i && pwrite_i && aofe_mapped(paddr_i))
                begin
                    if (paddr_i == AOFE_CTRL_OFFSET)
                    begin
                        next_ctrl = pwdata_i[AOFE_CTRL_W-1:0];
                    end
                    else if (paddr_i == AOFE_REFBOT_OFFSET)
                    begin
                        next_ref_bottom = pwdata_i[AOFE_IN_W-1:0];
                    end
                end
            end
            default:
            begin
                next_bus_state = AOFE_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            bus_state <= AOFE_BUS_IDLE;
            ctrl <= AOFE_CTRL_RESET;
            ref_bottom <= AOFE_REFBOT_RESET;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            bus_state <= next_bus_state;
            ctrl <= next_ctrl;
            ref_bottom <= next_ref_bottom;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

endmodule : aofe_core

`default_nettype wire

//--- hdl/aofe_pkg.sv
package aofe_pkg;

    // converter word and input widths
    localparam int AOFE_WORD_W = 10;
    localparam int AOFE_IN_W = 12;
    localparam int AOFE_MSB = 9;
    localparam int AOFE_PIPE_DEPTH = 2;

    // apb map
    localparam int AOFE_ADDR_W = 8;
    localparam logic [7:0] AOFE_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] AOFE_REFBOT_OFFSET = 8'h04;
    localparam logic [7:0] AOFE_STATUS_OFFSET = 8'h08;

    // ctrl: one bit per pin, set when the pin is really connected
    localparam int AOFE_CTRL_W = 5;
    localparam int AOFE_CONN_DEN_BIT = 0;
    localparam int AOFE_CONN_GEN_BIT = 1;
    localparam int AOFE_CONN_PHASE_BIT = 2;
    localparam int AOFE_CONN_MSB_INVERT_BIT = 3;
    localparam int AOFE_CONN_LOW_BITS_INVERT_BIT = 4;
    localparam logic [4:0] AOFE_CTRL_RESET = 5'h00;
    localparam logic [11:0] AOFE_REFBOT_RESET = 12'h000;

    // levels that the internal resistors give an open pin
    localparam logic AOFE_PULL_DEN_N = 1'b0;
    localparam logic AOFE_PULL_GEN = 1'b1;
    localparam logic AOFE_PULL_PHASE = 1'b1;
    localparam logic AOFE_PULL_MSB_INVERT = 1'b0;
    localparam logic AOFE_PULL_LOW_BITS_INVERT = 1'b0;

    // status layout
    localparam int AOFE_ST_OVER_BIT = 10;
    localparam int AOFE_ST_UNDER_BIT = 11;
    localparam int AOFE_ST_WINDOW_BIT = 12;
    localparam int AOFE_ST_PHASE_BIT = 13;

    localparam logic [9:0] AOFE_FULL_SCALE = 10'h3FF;
    localparam logic [9:0] AOFE_ZERO_SCALE = 10'h000;
    localparam logic [8:0] AOFE_LOW_MASK = 9'h1FF;
    localparam logic [12:0] AOFE_SPAN = 13'h3FF;

    typedef struct packed {
        logic over;
        logic under;
        logic [AOFE_WORD_W-1:0] word;
    } aofe_sample_type;

    typedef struct packed {
        logic den_n;
        logic gen;
        logic phase;
        logic msb_invert;
        logic low_bits_invert;
    } aofe_pins_type;

    typedef enum logic [1:0] {
        AOFE_BUS_IDLE = 2'b01,
        AOFE_BUS_ANSWER = 2'b10
    } aofe_bus_state_type;

endpackage : aofe_pkg

//--- testbench/aofe_core_checker.sv
`timescale 1ns/10ps
`default_nettype none
module aofe_core_checker
    import aofe_pkg::*;
(
    input wire logic sys_clk_i, // clock
    input wire logic nrst_i, // reset
    input wire logic conv_clk_i, // converter clock
    input wire logic psel_i, // select
    input wire logic penable_i, // enable
    input wire logic [AOFE_WORD_W-1:0] sample_word_o, // word
    input wire logic sample_word_oe_o, // word driven
    input wire logic over_range_flag_o, // over
    input wire logic over_range_flag_oe_o, // over driven
    input wire logic under_range_flag_o, // under
    input wire logic sample_window_o, // tracking
    input wire logic pready_o, // ready
    input wire logic pslverr_o // error
);
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_oe_nest:
    assert property (sample_word_oe_o |-> over_range_flag_oe_o)
        else $error("data driven with flags off");
    a_flags_apart:
    assert property (!(over_range_flag_o && under_range_flag_o))
        else $error("both flags high");
    a_forced_word:
    assert property ((over_range_flag_o || under_range_flag_o) |->
        sample_word_o inside {10'h3FF, 10'h1FF, 10'h200, 10'h000})
        else $error("forced word wrong");
    // output moves and window falls only shortly after a converter clock edge
    a_word_on_edge:
    assert property ($changed(sample_word_o) |-> $past(conv_clk_i) != $past(conv_clk_i, 2)
        || $past(conv_clk_i, 2) != $past(conv_clk_i, 3))
        else $error("word moved without edge");
    a_window_hold:
    assert property ($fell(sample_window_o) |-> $past(conv_clk_i) != $past(conv_clk_i, 2)
        || $past(conv_clk_i, 2) != $past(conv_clk_i, 3))
        else $error("window fell without edge");
    a_ready_pulse:
    assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    a_one_wait:
    assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
        else $error("ready late");
    a_err_ready:
    assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
endmodule : aofe_core_checker

bind aofe_core aofe_core_checker u_checker (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .conv_clk_i(conv_clk_i), .psel_i(psel_i), .penable_i(penable_i),
    .sample_word_o(sample_word_o), .sample_word_oe_o(sample_word_oe_o),
    .over_range_flag_o(over_range_flag_o), .over_range_flag_oe_o(over_range_flag_oe_o),
    .under_range_flag_o(under_range_flag_o), .sample_window_o(sample_window_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o));
`default_nettype wire

//--- testbench/aofe_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module aofe_host_model #(
    parameter int HALF = 4
)
(
    input wire logic sys_clk_i, // clock
    input wire logic run_i, // clock runs while high
    output logic conv_clk_o, // converter clock
    output logic half_end_o // last cycle of a half period
);
    int cnt = 0;
    initial conv_clk_o = 1'b0;
    assign half_end_o = run_i && cnt == HALF - 1;
    // stands still between frames; half periods span several cycles
    always @(posedge sys_clk_i)
    begin
        if (run_i)
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
                conv_clk_o <= ~conv_clk_o;
        end
    end
endmodule : aofe_host_model
`default_nettype wire

//--- testbench/adc_output_format_and_enable_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_output_format_and_enable_bench;
    import aofe_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, run = 1'b0, den_n = 1'b0, gen = 1'b1, ph = 1'b1;
    logic msb_invert = 1'b0, low_bits_invert = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, lfsr = 32'hE8D3, prdata, q;
    logic [11:0] ain = 12'h000, last, samp[$];
    logic [4:0] ctrl = 5'h00;
    logic [9:0] word;
    logic conv, half_end, word_oe, ovr, ovr_oe, und, und_oe, pready, pslverr, err, win;
    int bad_count = 0, check_count = 0, refbot = 0;

    always #50 clk = ~clk;

    aofe_core DUT (.sys_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .conv_clk_i(conv),
        .analog_input_i(ain), .data_out_enable_n_i(den_n), .global_out_enable_i(gen),
        .clk_phase_sel_i(ph), .msb_invert_i(msb_invert), .low_bits_invert_i(low_bits_invert),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .sample_word_o(word), .sample_word_oe_o(word_oe), .over_range_flag_o(ovr),
        .over_range_flag_oe_o(ovr_oe), .under_range_flag_o(und), .under_range_flag_oe_o(und_oe),
        .sample_window_o(win), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
    aofe_host_model #(.HALF(4)) host (.sys_clk_i(clk), .run_i(run), .conv_clk_o(conv),
        .half_end_o(half_end));

    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_step

    function automatic logic [11:0] model(input logic [11:0] v, input logic mi, input logic li);
        int d;
        logic [9:0] w;
        d = int'(v) - refbot;
        w = d < 0 ? 10'h000 : (d > 1023 ? 10'h3FF : d[9:0]);
        return {d < 0, d > 1023, w ^ {mi, {9{li}}}};
    endfunction : model

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    // word of sample n is checked at sample edge n+3, after its third output edge
    task automatic convert(input int count);
        int v;
        logic eph, egen;
        samp.delete();
        @(posedge clk);
        run <= 1'b1;
        for (int i = 0; i < count; i++)
        begin
            @(posedge clk);
            eph = ctrl[2] ? ph : 1'b1;
            while (!(half_end && conv === eph))
                @(posedge clk);
            egen = ctrl[1] ? gen : 1'b1;
            check({word_oe, ovr_oe, und_oe}, {egen && !(ctrl[0] && den_n), egen, egen});
            check(win, 1'b1);
            if (samp.size() >= 3)
            begin
                last = model(samp.pop_front(), ctrl[3] && msb_invert, ctrl[4] && low_bits_invert);
                check({und, ovr, word}, last);
            end
            lfsr = lfsr_step(lfsr);
            v = lfsr[10:0];
            if (i % 8 == 5)
                v = refbot + 1023;
            if (i % 8 == 6)
                v = refbot + 1024;
            if (i % 8 == 7)
                v = refbot - 1;
            ain <= 12'(v);
            samp.push_back(12'(v));
            {den_n, gen, msb_invert, low_bits_invert} <= lfsr[15:12];
        end
        run <= 1'b0;
    endtask : convert

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        convert(16);
        apb(1'b0, AOFE_STATUS_OFFSET, 32'h0);
        check(q[11:0], last);
        check(q[13], 1'b1);
        check(q[12], 1'b0);
        refbot = 256;
        apb(1'b1, AOFE_REFBOT_OFFSET, 32'h100);
        ctrl = 5'h1F;
        apb(1'b1, AOFE_CTRL_OFFSET, 32'h1F);
        apb(1'b0, AOFE_CTRL_OFFSET, 32'h0);
        check(q, 32'h1F);
        apb(1'b0, 8'h0C, 32'h0);
        check(err, 1'b1);
        convert(40);
        ph <= 1'b0;
        convert(40);
        conclude();
    end

    initial
    begin
        #2000000;
        bad_count++;
        conclude();
    end
endmodule : adc_output_format_and_enable_bench
`default_nettype wire
